// *** src/sfc_pkg.sv ***
// Package: types and constants for the script flow-control block
package sfc_pkg;
    // Program counter covers up to 99 stored commands
    localparam int SFC_PC_W = 7;
    localparam logic [SFC_PC_W-1:0] SFC_PC_STEP = 7'h01;
    localparam logic [SFC_PC_W-1:0] SFC_PC_ZERO = 7'h00;
    // Label letters a..z and A..Z
    localparam int SFC_NUM_LABELS = 52;
    localparam int SFC_SLOT_W = 6;
    localparam logic [7:0] SFC_CH_LA = 8'h61;
    localparam logic [7:0] SFC_CH_LZ = 8'h7A;
    localparam logic [7:0] SFC_CH_UA = 8'h41;
    localparam logic [7:0] SFC_CH_UZ = 8'h5A;
    localparam logic [7:0] SFC_UPPER_BASE = 8'h1A;
    // Digital user inputs 1..8
    localparam int SFC_UIN_N = 8;
    localparam logic [7:0] SFC_UIN_FIRST = 8'h01;
    localparam logic [7:0] SFC_UIN_LAST = 8'h08;
    // Flags
    localparam int SFC_FLAG_W = 64;
    localparam logic [7:0] SFC_FLAG_LIMIT = 8'h40;
    // Analog input in millivolts, 0..5000
    localparam int SFC_MV_W = 13;
    localparam logic [31:0] SFC_ANALOG_MAX_MV = 32'h0000_1388;
    // Operand and counter width; top bit must stay clear (0..2^31-1)
    localparam int SFC_VAL_W = 32;
    localparam int SFC_VAL_MSB = 31;
    localparam logic [31:0] SFC_VAL_ZERO = 32'h0000_0000;
    localparam logic [31:0] SFC_VAL_ONE = 32'h0000_0001;
    localparam logic [31:0] SFC_VAL_TWO = 32'h0000_0002;
    // Millisecond tick derived from the 250 MHz clock
    localparam int SFC_CLK_PERIOD_PS = 4000;
    localparam int SFC_TICK_PERIOD_MS = 1;
    localparam int SFC_PS_PER_MS = 1000000000;
    localparam int SFC_TICK_CYCLES =
        (SFC_TICK_PERIOD_MS * SFC_PS_PER_MS) / SFC_CLK_PERIOD_PS;
    localparam int SFC_TICK_CNT_W = 18;

    typedef enum logic [3:0] {
        SFC_OP_LABEL,
        SFC_OP_UNCOND_JUMP,
        SFC_OP_FLAG_JUMP,
        SFC_OP_INPUT_JUMP,
        SFC_OP_ANALOG_GT,
        SFC_OP_ANALOG_LT,
        SFC_OP_COUNT_LT,
        SFC_OP_COUNT_EQ,
        SFC_OP_COUNT_GT,
        SFC_OP_POS_LT,
        SFC_OP_POS_EQ,
        SFC_OP_POS_GT,
        SFC_OP_GROUP_START,
        SFC_OP_GROUP_END,
        SFC_OP_MS_DELAY
    } sfc_op_t;

    // One decoded script command, operand already resolved from variables
    typedef struct packed {
        sfc_op_t op;
        logic [7:0] label;
        logic negate;
        logic [7:0] index;
        logic [SFC_VAL_W-1:0] operand;
        logic [SFC_PC_W-1:0] pc;
    } sfc_cmd_t;

    // Label definition from the script loader
    typedef struct packed {
        logic valid;
        logic [7:0] label;
        logic [SFC_PC_W-1:0] pc;
    } sfc_label_def_t;

    typedef struct packed {
        logic def;
        logic [SFC_PC_W-1:0] pc;
    } sfc_label_ent_t;

    // Answer to each command
    typedef struct packed {
        logic valid;
        logic err;
        logic jumped;
        logic [SFC_PC_W-1:0] next_pc;
    } sfc_resp_t;
endpackage

// *** src/sfc_ms_tick.sv ***
// Free-running millisecond tick generator
`timescale 1ns/1ns
module sfc_ms_tick
    import sfc_pkg::*;
#(
    parameter int TICK_CYCLES = SFC_TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    output logic tick
);
    localparam logic [SFC_TICK_CNT_W-1:0] TICK_LAST =
        SFC_TICK_CNT_W'(TICK_CYCLES - 1);
    localparam logic [SFC_TICK_CNT_W-1:0] CNT_ONE = 18'h00001;

    typedef struct packed {
        logic [SFC_TICK_CNT_W-1:0] cnt;
        logic tick;
    } sfc_tick_state_t;

    sfc_tick_state_t s_r;
    sfc_tick_state_t s_nxt;

    // Never stops, so a delay can start anywhere inside a tick period
    always_comb begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        if (s_r.cnt == TICK_LAST) begin
            s_nxt.cnt = '0;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.cnt = s_r.cnt + CNT_ONE;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tick = s_r.tick;
endmodule

// *** src/sfc_flow_ctrl.sv ***
// Script flow control: labels, jumps, repeat groups and ms delays
`timescale 1ns/1ns
// Notes on behaviour
// (R1) A script may define a label named by one upper- or lower-case letter.
// (R2) An unconditional jump always continues after the named label.
// (R3) A conditional jump goes to the label only when its test is true.
// (R4) The flag jump branches on a set flag, its negated form on a clear one.
// (R5) The input jump branches when user input 1..8 reads true.
// (R6) Analog jumps branch on input strictly above or below 0..5000 mV.
// (R7) Counter jumps branch on less, equal or greater against 0..2^31-1.
// (R8) Position jumps compare the syringe step position within its limits.
// (R9) A label with a backward jump repeats until a conditional jump exits.
// (R10) Group start marks a group that group end with count n runs n times.
// (R11) A group end count of zero repeats the group without end.
// (R12) The delay pauses n ms, 1..2^31-1, before the next command runs.
// (R13) The delay counts down on a free-running 1 ms tick, so may run short.
// (R14) A writer needing a sure minimum pause adds one to the delay count.
// (R15) The counter tested by counter jumps is accumulator zero.
// (R16) A jump to an undefined label reports an error and stops the script.
module sfc_flow_ctrl
    import sfc_pkg::*;
#(
    parameter int TICK_CYCLES = SFC_TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic script_clear,
    input wire sfc_label_def_t label_def,
    input wire logic cmd_valid,
    input wire sfc_cmd_t cmd,
    output logic cmd_ready,
    output sfc_resp_t resp,
    output logic halted,
    input wire logic [SFC_FLAG_W-1:0] flags,
    input wire logic [SFC_UIN_N-1:0] user_in,
    input wire logic [SFC_MV_W-1:0] analog_mv,
    input wire logic [SFC_VAL_W-1:0] acc0,
    input wire logic [SFC_VAL_W-1:0] position,
    input wire logic [SFC_VAL_W-1:0] pos_lower,
    input wire logic [SFC_VAL_W-1:0] pos_upper
);
    typedef struct packed {
        sfc_label_ent_t [SFC_NUM_LABELS-1:0] labels;
        logic [SFC_UIN_N-1:0] uin_s1;
        logic [SFC_UIN_N-1:0] uin_s2;
        logic loop_act;
        logic loop_counting;
        logic [SFC_PC_W-1:0] loop_pc;
        logic [SFC_VAL_W-1:0] loop_left;
        logic delay_act;
        logic [SFC_PC_W-1:0] delay_pc;
        logic [SFC_VAL_W-1:0] delay_left;
        logic ready;
        logic halted;
        sfc_resp_t resp;
    } sfc_state_t;

    sfc_state_t s_r;
    sfc_state_t s_nxt;
    logic tick;
    logic take;
    logic is_jump;
    logic cond;
    logic bad_arg;
    logic [SFC_SLOT_W:0] slot;
    sfc_label_ent_t ent;
    logic [SFC_SLOT_W:0] def_slot;
    logic [SFC_VAL_W-1:0] mv_ext;
    logic [SFC_PC_W-1:0] seq_pc;

    // Maps a label letter to its table slot; top bit says the letter is legal
    function automatic logic [SFC_SLOT_W:0] sfc_label_slot(
        input logic [7:0] ch
    );
        logic [7:0] idx;
        idx = 8'h00;
        if (ch >= SFC_CH_LA && ch <= SFC_CH_LZ) begin
            idx = ch - SFC_CH_LA;
            return {1'b1, idx[SFC_SLOT_W-1:0]};
        end else if (ch >= SFC_CH_UA && ch <= SFC_CH_UZ) begin
            idx = ch - SFC_CH_UA + SFC_UPPER_BASE;
            return {1'b1, idx[SFC_SLOT_W-1:0]};
        end
        return '0;
    endfunction

    sfc_ms_tick #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk(clk),
        .rstn(rstn),
        .tick(tick)
    );

    assign take = cmd_valid && s_r.ready;
    assign slot = sfc_label_slot(cmd.label);
    assign ent = s_r.labels[slot[SFC_SLOT_W-1:0]];
    assign def_slot = sfc_label_slot(label_def.label);
    assign mv_ext = SFC_VAL_W'(analog_mv);
    assign seq_pc = cmd.pc + SFC_PC_STEP;

    // Condition decode for every jump type
    always_comb begin
        is_jump = 1'b1;
        cond = 1'b0;
        bad_arg = 1'b0;
        unique case (cmd.op)
            // (R2) always taken
            SFC_OP_UNCOND_JUMP: begin
                cond = 1'b1;
            end
            // (R4) flag set or clear
            SFC_OP_FLAG_JUMP: begin
                bad_arg = cmd.index >= SFC_FLAG_LIMIT;
                if (!bad_arg) begin
                    cond = flags[cmd.index[5:0]] ^ cmd.negate;
                end
            end
            // (R5) synchronised user input
            SFC_OP_INPUT_JUMP: begin
                bad_arg = cmd.index < SFC_UIN_FIRST ||
                    cmd.index > SFC_UIN_LAST;
                if (!bad_arg) begin
                    cond = s_r.uin_s2[3'(cmd.index - SFC_UIN_FIRST)];
                end
            end
            // (R6) strict analog compare
            SFC_OP_ANALOG_GT, SFC_OP_ANALOG_LT: begin
                bad_arg = cmd.operand > SFC_ANALOG_MAX_MV;
                cond = (cmd.op == SFC_OP_ANALOG_GT) ?
                    (mv_ext > cmd.operand) : (mv_ext < cmd.operand);
            end
            // (R7) (R15) accumulator zero compare
            SFC_OP_COUNT_LT, SFC_OP_COUNT_EQ, SFC_OP_COUNT_GT: begin
                bad_arg = cmd.operand[SFC_VAL_MSB];
                cond = (cmd.op == SFC_OP_COUNT_LT) ? (acc0 < cmd.operand) :
                    (cmd.op == SFC_OP_COUNT_EQ) ? (acc0 == cmd.operand) :
                    (acc0 > cmd.operand);
            end
            // (R8) position within limits
            SFC_OP_POS_LT, SFC_OP_POS_EQ, SFC_OP_POS_GT: begin
                bad_arg = cmd.operand < pos_lower ||
                    cmd.operand > pos_upper;
                cond = (cmd.op == SFC_OP_POS_LT) ?
                    (position < cmd.operand) :
                    (cmd.op == SFC_OP_POS_EQ) ?
                    (position == cmd.operand) :
                    (position > cmd.operand);
            end
            default: begin
                is_jump = 1'b0;
            end
        endcase
        // (R3) false test falls through
        if (bad_arg) begin
            cond = 1'b0;
        end
    end

    // Next state: one command at a time; delay holds off the next one
    always_comb begin
        s_nxt = s_r;
        s_nxt.resp.valid = 1'b0;
        s_nxt.resp.err = 1'b0;
        s_nxt.resp.jumped = 1'b0;
        // Two stages before any logic looks at the pins
        s_nxt.uin_s1 = user_in;
        s_nxt.uin_s2 = s_r.uin_s1;
        // Only reset leaves ready low with no halt and no delay pending
        if (!s_r.ready && !s_r.halted && !s_r.delay_act) begin
            s_nxt.ready = 1'b1;
        end

        // (R13) countdown on shared tick
        if (s_r.delay_act && tick) begin
            if (s_r.delay_left <= SFC_VAL_ONE) begin
                s_nxt.delay_act = 1'b0;
                s_nxt.delay_left = SFC_VAL_ZERO;
                s_nxt.ready = 1'b1;
                s_nxt.resp.valid = 1'b1;
                s_nxt.resp.next_pc = s_r.delay_pc + SFC_PC_STEP;
            end else begin
                s_nxt.delay_left = s_r.delay_left - SFC_VAL_ONE;
            end
        end

        if (take) begin
            s_nxt.resp.valid = 1'b1;
            s_nxt.resp.next_pc = seq_pc;
            if (is_jump) begin
                if (bad_arg) begin
                    s_nxt.resp.err = 1'b1;
                end else if (cond) begin
                    // (R16) undefined label stops
                    if (!slot[SFC_SLOT_W] || !ent.def) begin
                        s_nxt.resp.err = 1'b1;
                    end else begin
                        // (R9) backward jumps loop freely
                        s_nxt.resp.jumped = 1'b1;
                        s_nxt.resp.next_pc = ent.pc + SFC_PC_STEP;
                    end
                end
            end else begin
                unique case (cmd.op)
                    // (R1) record label position
                    SFC_OP_LABEL: begin
                        if (slot[SFC_SLOT_W]) begin
                            s_nxt.labels[slot[SFC_SLOT_W-1:0]] =
                                '{def: 1'b1, pc: cmd.pc};
                        end else begin
                            s_nxt.resp.err = 1'b1;
                        end
                    end
                    // (R10) mark group start
                    SFC_OP_GROUP_START: begin
                        s_nxt.loop_act = 1'b1;
                        s_nxt.loop_counting = 1'b0;
                        s_nxt.loop_pc = cmd.pc;
                    end
                    SFC_OP_GROUP_END: begin
                        if (!s_r.loop_act || cmd.operand[SFC_VAL_MSB]) begin
                            s_nxt.resp.err = 1'b1;
                        // (R11) zero count never ends
                        end else if (cmd.operand == SFC_VAL_ZERO) begin
                            s_nxt.resp.jumped = 1'b1;
                            s_nxt.resp.next_pc = s_r.loop_pc + SFC_PC_STEP;
                        // (R10) run group n times
                        end else if (!s_r.loop_counting) begin
                            if (cmd.operand > SFC_VAL_ONE) begin
                                s_nxt.loop_counting = 1'b1;
                                s_nxt.loop_left = cmd.operand - SFC_VAL_TWO;
                                s_nxt.resp.jumped = 1'b1;
                                s_nxt.resp.next_pc =
                                    s_r.loop_pc + SFC_PC_STEP;
                            end else begin
                                s_nxt.loop_act = 1'b0;
                            end
                        end else if (s_r.loop_left != SFC_VAL_ZERO) begin
                            s_nxt.loop_left = s_r.loop_left - SFC_VAL_ONE;
                            s_nxt.resp.jumped = 1'b1;
                            s_nxt.resp.next_pc = s_r.loop_pc + SFC_PC_STEP;
                        end else begin
                            s_nxt.loop_act = 1'b0;
                            s_nxt.loop_counting = 1'b0;
                        end
                    end
                    // (R12) start the pause; answer comes at the end
                    SFC_OP_MS_DELAY: begin
                        if (cmd.operand == SFC_VAL_ZERO ||
                            cmd.operand[SFC_VAL_MSB]) begin
                            s_nxt.resp.err = 1'b1;
                        end else begin
                            s_nxt.resp.valid = 1'b0;
                            s_nxt.ready = 1'b0;
                            s_nxt.delay_act = 1'b1;
                            s_nxt.delay_pc = cmd.pc;
                            s_nxt.delay_left = cmd.operand;
                        end
                    end
                    default: begin
                        s_nxt.resp.err = 1'b1;
                    end
                endcase
            end
            // (R16) stop after any error
            if (s_nxt.resp.err) begin
                s_nxt.halted = 1'b1;
                s_nxt.ready = 1'b0;
                s_nxt.resp.next_pc = cmd.pc;
            end
        end

        // Loader defines labels ahead so forward jumps resolve
        if (label_def.valid && def_slot[SFC_SLOT_W]) begin
            s_nxt.labels[def_slot[SFC_SLOT_W-1:0]] =
                '{def: 1'b1, pc: label_def.pc};
        end

        // New script wipes labels, loop and any pending delay
        if (script_clear) begin
            s_nxt.labels = '0;
            s_nxt.loop_act = 1'b0;
            s_nxt.loop_counting = 1'b0;
            s_nxt.loop_left = SFC_VAL_ZERO;
            s_nxt.delay_act = 1'b0;
            s_nxt.delay_left = SFC_VAL_ZERO;
            s_nxt.halted = 1'b0;
            s_nxt.ready = 1'b1;
            s_nxt.resp.valid = 1'b0;
            s_nxt.resp.next_pc = SFC_PC_ZERO;
        end
    end

    // One register for all state; ready comes up one edge after reset
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign cmd_ready = s_r.ready;
    assign resp = s_r.resp;
    assign halted = s_r.halted;
endmodule

// *** tb/sfc_flow_ctrl_asserts.sv ***
// Port checker for the script flow-control block
`timescale 1ns/1ns
module sfc_flow_ctrl_asserts
    import sfc_pkg::*;
#(
    parameter int TICK_CYCLES = SFC_TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic script_clear,
    input wire logic cmd_valid,
    input wire sfc_cmd_t cmd,
    input wire logic cmd_ready,
    input wire sfc_resp_t resp,
    input wire logic halted,
    input wire logic [SFC_FLAG_W-1:0] flags,
    input wire logic [SFC_MV_W-1:0] analog_mv,
    input wire logic [SFC_VAL_W-1:0] acc0
);
    logic take;
    logic quick;
    logic flag_hit;
    logic mv_hit;
    logic acc_hit;
    // Take at this edge and the test results the command sees
    assign take = cmd_valid && cmd_ready && !script_clear;
    assign quick = take && cmd.op != SFC_OP_MS_DELAY;
    assign flag_hit = flags[cmd.index[5:0]] ^ cmd.negate;
    assign mv_hit = analog_mv > cmd.operand;
    assign acc_hit = acc0 == cmd.operand;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    // Every command but a legal delay answers on the next edge
    a_answer_next: assert property (quick |=> resp.valid)
        else $error("no answer after a command");
    a_jump_always: assert property (take &&
        cmd.op == SFC_OP_UNCOND_JUMP |=> resp.jumped || resp.err)
        else $error("unconditional jump not taken");
    a_fall_through: assert property (quick |=> resp.jumped ||
        resp.err || resp.next_pc == $past(cmd.pc) + SFC_PC_STEP)
        else $error("fall-through pc wrong");
    // Test outcomes; an undefined label may still turn them into errors
    a_flag_test: assert property (take &&
        cmd.op == SFC_OP_FLAG_JUMP && cmd.index < SFC_FLAG_LIMIT
        |=> resp.err || resp.jumped == $past(flag_hit))
        else $error("flag jump outcome wrong");
    a_analog_gt: assert property (take &&
        cmd.op == SFC_OP_ANALOG_GT && cmd.operand <= SFC_ANALOG_MAX_MV
        |=> resp.err || resp.jumped == $past(mv_hit))
        else $error("analog jump outcome wrong");
    a_counter_eq: assert property (take &&
        cmd.op == SFC_OP_COUNT_EQ && !cmd.operand[SFC_VAL_MSB]
        |=> resp.err || resp.jumped == $past(acc_hit))
        else $error("counter jump outcome wrong");
    // An error stops the script at the failing command
    a_error_halts: assert property (resp.valid && resp.err |->
        halted && !cmd_ready && resp.next_pc == $past(cmd.pc))
        else $error("error did not halt");
    a_halt_holds: assert property (halted && !script_clear
        |=> halted && !cmd_ready)
        else $error("halt released without clear");
    a_clear_frees: assert property (script_clear |=> !halted)
        else $error("clear left the block halted");
    // Needs TICK_CYCLES of 7 or more: the answer after the second tick can't show within 8 cycles
    a_delay_waits: assert property (take &&
        cmd.op == SFC_OP_MS_DELAY && cmd.operand == SFC_VAL_TWO
        |=> (!cmd_ready && !resp.valid) [*8])
        else $error("delay ended too early");
endmodule
bind sfc_flow_ctrl sfc_flow_ctrl_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .clk(clk), .rstn(rstn), .script_clear(script_clear),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
    .resp(resp), .halted(halted), .flags(flags),
    .analog_mv(analog_mv), .acc0(acc0));

// *** tb/sfc_host_model.sv ***
// Host side: offers script commands and loader label writes
`timescale 1ns/1ns
module sfc_host_model
    import sfc_pkg::*;
(
    input wire logic clk,
    input wire logic cmd_ready,
    input wire sfc_resp_t resp,
    output sfc_label_def_t label_def,
    output sfc_cmd_t cmd,
    output logic cmd_valid
);
    // Idle at time zero
    initial begin
        label_def = '0;
        cmd = '0;
        cmd_valid = 1'b0;
    end
    // One-cycle loader write; released fields show their inverse
    task automatic put_label(input logic [7:0] ch, input logic [6:0] pc);
        @(negedge clk);
        label_def = '{1'b1, ch, pc};
        @(negedge clk);
        label_def = '{1'b0, ~ch, ~pc};
    endtask
    // Hold the request until ready is seen, then wait for the answer
    task automatic send(input sfc_cmd_t c, output sfc_resp_t r,
        output int cyc);
        @(negedge clk);
        cmd = c;
        cmd_valid = 1'b1;
        while (cmd_ready !== 1'b1)
            @(negedge clk);
        @(posedge clk);
        @(negedge clk);
        cmd_valid = 1'b0;
        // Stale command must never look valid, so drive its inverse
        cmd = sfc_cmd_t'(~c);
        cyc = 0;
        while (resp.valid !== 1'b1) begin
            @(negedge clk);
            cyc++;
        end
        r = resp;
    endtask
endmodule

// *** tb/sfc_flow_ctrl_tb_top.sv ***
// Self-checking bench for the script flow-control block
`timescale 1ns/1ns
module sfc_flow_ctrl_tb_top
    import sfc_pkg::*;
;
    localparam int TICK = 10;
    localparam logic [7:0] LB_UNDEF = 8'h71;
    localparam logic [7:0] LB_BAD = 8'h31;
    // Commands that must each be refused with an error
    localparam sfc_op_t EOP [10] = '{SFC_OP_UNCOND_JUMP, SFC_OP_FLAG_JUMP,
        SFC_OP_INPUT_JUMP, SFC_OP_INPUT_JUMP, SFC_OP_ANALOG_LT,
        SFC_OP_COUNT_GT, SFC_OP_POS_EQ, SFC_OP_GROUP_END, SFC_OP_MS_DELAY,
        SFC_OP_LABEL};
    localparam logic [7:0] EIX [10] = '{8'h00, 8'h40, 8'h00, 8'h09,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [31:0] EVAL [10] = '{32'h0, 32'h0, 32'h0, 32'h0,
        32'h1389, 32'h8000_0000, 32'h5, 32'h2, 32'h0, 32'h0};
    logic clk;
    logic rstn;
    logic script_clear;
    logic [SFC_FLAG_W-1:0] flags;
    logic [SFC_UIN_N-1:0] user_in;
    logic [SFC_MV_W-1:0] analog_mv;
    logic [SFC_VAL_W-1:0] acc0;
    logic [SFC_VAL_W-1:0] position;
    logic [SFC_VAL_W-1:0] pos_lower;
    logic [SFC_VAL_W-1:0] pos_upper;
    sfc_label_def_t label_def;
    logic cmd_valid;
    sfc_cmd_t cmd;
    logic cmd_ready;
    sfc_resp_t resp;
    logic halted;
    sfc_resp_t r;
    logic [6:0] at;
    logic [6:0] tgt;
    int cyc;
    int errors = 0;
    int tests_run = 0;
    int cycles = 0;
    sfc_flow_ctrl #(.TICK_CYCLES(TICK)) dut (
        .clk(clk), .rstn(rstn), .script_clear(script_clear),
        .label_def(label_def), .cmd_valid(cmd_valid), .cmd(cmd),
        .cmd_ready(cmd_ready), .resp(resp), .halted(halted),
        .flags(flags), .user_in(user_in), .analog_mv(analog_mv),
        .acc0(acc0), .position(position), .pos_lower(pos_lower),
        .pos_upper(pos_upper));
    sfc_host_model host (
        .clk(clk), .cmd_ready(cmd_ready), .resp(resp),
        .label_def(label_def), .cmd(cmd), .cmd_valid(cmd_valid));
    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Cycle ceiling, far above what all scenarios together need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            report_and_stop();
        end
    end
    task automatic chk(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s exp %0h seen %0h", nm, exp, seen);
        end
    endtask
    // One command at pc 'at'; a jump lands on 'tgt', an error on 'at', else on at+1
    task automatic ex(input sfc_op_t op, input logic [31:0] v,
        input logic j, input logic [7:0] ix = 8'h00, input logic ng = 1'b0,
        input logic [7:0] lb = SFC_CH_LA, input logic e = 1'b0);
        host.send('{op, lb, ng, ix, v, at}, r, cyc);
        chk("resp_err", r.err, e);
        chk("resp_next_pc", r.next_pc, e ? at : (j ? tgt : at + 7'h01));
        if (!e)
            chk("resp_jumped", r.jumped, j);
    endtask
    task automatic clear_script();
        @(negedge clk);
        script_clear = 1'b1;
        @(negedge clk);
        script_clear = 1'b0;
    endtask
    task automatic t_jumps();
        host.put_label(SFC_CH_LA, 7'h03);
        at = 7'h0A;
        ex(SFC_OP_LABEL, SFC_VAL_ZERO, 1'b0, 8'h00, 1'b0, SFC_CH_UZ);
        at = 7'h07;
        tgt = 7'h04;
        repeat (2) ex(SFC_OP_UNCOND_JUMP, SFC_VAL_ZERO, 1'b1);
        tgt = 7'h0B;
        ex(SFC_OP_UNCOND_JUMP, SFC_VAL_ZERO, 1'b1, 8'h00, 1'b0,
            SFC_CH_UZ);
    endtask
    task automatic t_tests();
        int i;
        at = 7'h08;
        tgt = 7'h04;
        // Flag five set or clear, plain and negated
        for (i = 0; i < 4; i++) begin
            flags = {58'h0, i[1], 5'h00};
            ex(SFC_OP_FLAG_JUMP, SFC_VAL_ZERO, i[1] ^ i[0], 8'h05, i[0]);
        end
        user_in = 8'h04;
        repeat (3) @(negedge clk);
        for (i = 1; i <= 8; i++)
            ex(SFC_OP_INPUT_JUMP, SFC_VAL_ZERO, i == 3, 8'(i));
        analog_mv = 13'h09B0;
        ex(SFC_OP_ANALOG_GT, 32'h09AF, 1'b1);
        ex(SFC_OP_ANALOG_GT, 32'h09B0, 1'b0);
        ex(SFC_OP_ANALOG_LT, 32'h09B1, 1'b1);
        ex(SFC_OP_ANALOG_LT, 32'h09B0, 1'b0);
        ex(SFC_OP_ANALOG_GT, SFC_ANALOG_MAX_MV, 1'b0);
    endtask
    task automatic t_compare();
        int k;
        int d;
        logic [31:0] b;
        logic [31:0] v;
        // Counter then position, each less, equal, greater, one off
        for (k = 0; k < 6; k++)
            for (d = 0; d < 3; d++) begin
                b = (k < 3) ? acc0 : position;
                v = b - 32'h1 + 32'(d);
                ex(sfc_op_t'(SFC_OP_COUNT_LT + k), v,
                    (k % 3 == 0) ? b < v : (k % 3 == 1) ? b == v : b > v);
            end
        ex(SFC_OP_COUNT_LT, 32'h7FFF_FFFF, 1'b1);
    endtask
    task automatic t_group();
        int n;
        int i;
        int cnt [3] = '{3, 1, 0};
        tgt = 7'h15;
        for (n = 0; n < 3; n++) begin
            at = 7'h14;
            ex(SFC_OP_GROUP_START, SFC_VAL_ZERO, 1'b0);
            at = 7'h19;
            for (i = 1; i <= ((cnt[n] == 0) ? 4 : cnt[n]); i++)
                ex(SFC_OP_GROUP_END, 32'(cnt[n]),
                    cnt[n] == 0 || i < cnt[n]);
        end
    endtask
    task automatic t_delay();
        int n;
        at = 7'h1E;
        for (n = 1; n <= 3; n++) begin
            ex(SFC_OP_MS_DELAY, 32'(n), 1'b0);
            chk("delay_min", cyc >= (n - 1) * TICK, 1'b1);
            chk("delay_max", cyc <= n * TICK + 1, 1'b1);
        end
    endtask
    task automatic t_errors();
        int i;
        at = 7'h28;
        ex(SFC_OP_COUNT_EQ, 32'h5, 1'b0, 8'h00, 1'b0, LB_UNDEF);
        for (i = 0; i < 10; i++) begin
            ex(EOP[i], EVAL[i], 1'b0, EIX[i], 1'b0,
                (EOP[i] == SFC_OP_LABEL) ? LB_BAD : LB_UNDEF, 1'b1);
            chk("halted", halted, 1'b1);
            chk("ready_halted", cmd_ready, 1'b0);
            clear_script();
            chk("halt_cleared", halted, 1'b0);
        end
    endtask
    task automatic report_and_stop();
        if (errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Reset, then the scenarios in order; errors last as they clear labels
    initial begin
        rstn = 1'b0;
        script_clear = 1'b0;
        flags = '0;
        user_in = 8'h00;
        analog_mv = 13'h0000;
        acc0 = 32'h64;
        position = 32'h32;
        pos_lower = 32'h0A;
        pos_upper = 32'h0BB8;
        at = 7'h00;
        tgt = 7'h00;
        repeat (5) @(negedge clk);
        rstn = 1'b1;
        repeat (2) @(negedge clk);
        t_jumps();
        t_tests();
        t_compare();
        t_group();
        t_delay();
        t_errors();
        report_and_stop();
    end
endmodule
